// ==== design/irq_status_consts.svh ====
// Constants of the interrupt status and DMA source register block.
// Assumes inclusion by bare name from the register module and the bench.
`ifndef IRQ_STATUS_CONSTS_SVH
`define IRQ_STATUS_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_EOI           8'h22
`define IDX_PRIO_THRESH   8'h2A
`define IDX_SRC_MASK      8'h28
`define IDX_IN_SERVICE    8'h2C
`define IDX_PENDING       8'h2E
`define IDX_STATUS        8'h30
`define IDX_DMA0_CTL      8'h34
`define IDX_DMA1_CTL      8'h36

// Reset values
`define RST_SRC_CTL       16'h000F
`define RST_PRIO_THRESH   3'h7
`define RST_FLAGS         16'h0000

// Field positions
`define BIT_SRC_MASK      3
`define BIT_DMA_HALT      15
`define BIT_SERIAL        10
`define BIT_WDOG          9
`define BIT_EXT_LO        4
`define BIT_DMA_LO        2
`define BIT_TIMER0_REQUEST_BIT          0
`define BIT_TIMER1_REQUEST_BIT_SLAVE    4
`define BIT_TIMER2_REQUEST_BIT_SLAVE    5
`define BIT_EOI_NONSPEC   15

// Interrupt types
`define TYPE_TIMER0_REQUEST_BIT         8'h08
`define TYPE_TIMER1_REQUEST_BIT         8'h12
`define TYPE_TIMER2_REQUEST_BIT         8'h13
`define TYPE_DMA0         8'h0A
`define TYPE_DMA1         8'h0B
`define TYPE_EXT0         8'h0C
`define TYPE_WDOG         8'h11
`define TYPE_SERIAL       8'h14

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ==== design/irq_status_pkg.sv ====
// Types of the interrupt status and DMA source register block.
// Assumes the constants header sits beside it.
package irq_status_pkg;
    typedef struct packed {
        logic       mask;
        logic [2:0] prio;
    } src_ctl_s;

    typedef enum logic [0:0] {
        WR_IDLE,
        WR_RESP
    } wr_state_e;
endpackage

// ==== design/irq_status_regs.sv ====
// Interrupt status, request, in-service and DMA source control registers.
// Assumes an AXI4-Lite master on CLOCK and same-clock interrupt sources.
//
// Functional notes
// [R1] DMA channel 0 supplies type 0Ah, channel 1 supplies type 0Bh.
// [R2] Both DMA source control registers reset to 000Fh in either mode.
// [R3] Mask bit 3 at zero lets the source request; mirrored in mask register.
// [R4] Priority field bits 2-0 in each control register, reset to 7.
// [R5] DMA control setting picks external interrupt or DMA request per shared pin.
// [R6] Slave mode keeps the same control register offsets and layout.
// [R7] DMA halt flag at bit 15 set stops all DMA transfer activity.
// [R8] Halt flag sets on any non-maskable interrupt, clears on interrupt return.
// [R9] Master software may write the halt flag; this also writes timer bits.
// [R10] Status bits 2-0 show pending requests of timers 2, 1 and 0.
// [R11] Master request bit 0 is the OR of the three timer bits.
// [R12] Request register is read-only and shows the presented request lines.
// [R13] Master request layout: serial 10, watchdog 9, external 8-4, DMA 3-2, timer 0.
// [R14] Serial request, when enabled, is the OR of six serial sources.
// [R15] Slave request bits set on request, clear on acknowledge, reset to zero.
// [R16] Slave request layout: timer2 5, timer1 4, DMA 3-2, timer0 0.
// [R17] In-service bit sets when taken, clears on matching end-of-interrupt write.
// [R18] A source in service raises no further request.
// [R19] External inputs 0 and 1 in special nested mode bypass that blocking.
// [R20] Master in-service resets to zero with the master request layout.
// [R21] Slave in-service is read-only: timer2 5, timer1 4, DMA 3-2, timer0 0.
// [R22] Priority 0 highest; sources above the threshold field are masked.
// [R23] Mask register bit write equals writing the source mask bit.
// [R24] Reserved bits read zero and ignore writes.
// [R25] Mode input selects master or slave layouts and behaviour.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "irq_status_consts.svh"

module irq_status_regs
    import irq_status_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    // AXI4-Lite slave
    input  wire logic [9:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [9:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Mode and core events
    input  wire logic        SLAVE_MODE,
    input  wire logic        NMI_EVENT,
    input  wire logic        RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC,
    input  wire logic        TAKE,
    input  wire logic [7:0]  TAKE_TYPE,
    // Interrupt sources
    input  wire logic [2:0]  TIMER_REQ,
    input  wire logic [1:0]  DMA_DONE,
    input  wire logic [4:0]  EXT_REQ,
    input  wire logic [1:0]  EXT_NESTED,
    input  wire logic        WDOG_REQ,
    input  wire logic [5:0]  SERIAL_SRC,
    input  wire logic        SERIAL_EN,
    // Shared DMA pins and their DMA control setting
    input  wire logic [1:0]  SHARED_PIN,
    input  wire logic [1:0]  PIN_IS_IRQ,
    // Outputs to DMA and core
    output logic             DMA_HALT,
    output logic [1:0]       DMA_PIN_REQ,
    output logic             DMA_IRQ,
    output logic [7:0]       DMA_IRQ_TYPE,
    output logic [15:0]      REQ_UNBLOCKED
);

    src_ctl_s    dma_ctl [2];
    wr_state_e   wr_state;
    logic [2:0]  prio_thresh;
    logic        halt;
    logic [2:0]  tmr_pend;
    logic [1:0]  dma_pend;
    logic [15:0] slv_pend;
    logic [15:0] in_service;
    logic [1:0]  pin_meta;
    logic [1:0]  pin_sync;
    logic [1:0]  pin_prev;
    logic        aw_held;
    logic        w_held;
    logic [9:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [15:0] req_master;
    logic [15:0] req_view;
    logic [15:0] wr_val;
    logic [15:0] take_bit;
    logic [15:0] eoi_bit;
    logic [15:0] block;
    logic [1:0]  dma_set;
    logic [1:0]  dma_ok;
    logic [2:0]  tmr_take;
    logic        wr_fire;
    logic [7:0]  wr_idx;
    logic        wr_hit;
    logic [7:0]  rd_idx;

    // One-hot flag position of an interrupt type in the selected layout
    function automatic logic [15:0] type_bit(input logic [7:0] t, input logic slave);
        logic [15:0] b;
        b = 16'h0000;
        if (t == `TYPE_TIMER0_REQUEST_BIT) b[`BIT_TIMER0_REQUEST_BIT] = 1'b1;
        if (t == `TYPE_DMA0) b[`BIT_DMA_LO] = 1'b1;
        if (t == `TYPE_DMA1) b[`BIT_DMA_LO + 1] = 1'b1;
        if (slave) begin
            if (t == `TYPE_TIMER1_REQUEST_BIT) b[`BIT_TIMER1_REQUEST_BIT_SLAVE] = 1'b1;
            if (t == `TYPE_TIMER2_REQUEST_BIT) b[`BIT_TIMER2_REQUEST_BIT_SLAVE] = 1'b1;
        end else begin
            if (t == `TYPE_TIMER1_REQUEST_BIT || t == `TYPE_TIMER2_REQUEST_BIT) b[`BIT_TIMER0_REQUEST_BIT] = 1'b1;
            if (t >= `TYPE_EXT0 && t <= `TYPE_EXT0 + 8'h04) begin
                b[`BIT_EXT_LO + 32'(t - `TYPE_EXT0)] = 1'b1;
            end
            if (t == `TYPE_WDOG) b[`BIT_WDOG] = 1'b1;
            if (t == `TYPE_SERIAL) b[`BIT_SERIAL] = 1'b1;
        end
        return b;
    endfunction

    // Shared pin synchroniser and edge detect
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
        end else begin
            pin_meta <= SHARED_PIN;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Write channel capture and decode
    assign wr_fire = aw_held && w_held && wr_state == WR_IDLE;
    assign wr_idx  = aw_addr[9:2];
    assign wr_val  = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
    assign rd_idx  = ARADDR[9:2];

    always_comb begin
        wr_hit = 1'b1;
        case (wr_idx)
            `IDX_EOI, `IDX_PRIO_THRESH, `IDX_SRC_MASK, `IDX_IN_SERVICE,
            `IDX_PENDING, `IDX_STATUS, `IDX_DMA0_CTL, `IDX_DMA1_CTL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wr_state <= WR_IDLE;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 10'h000;
            w_data   <= 32'h0000_0000;
            w_strb   <= 4'h0;
            AWREADY  <= 1'b0;
            WREADY   <= 1'b0;
            BVALID   <= 1'b0;
            BRESP    <= `RESP_OKAY;
        end else begin
            AWREADY <= !aw_held && !AWREADY && wr_state == WR_IDLE;
            WREADY  <= !w_held && !WREADY && wr_state == WR_IDLE;
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            case (wr_state)
                WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state <= WR_RESP;
                        BVALID   <= 1'b1;
                        BRESP    <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                        aw_held  <= 1'b0;
                        w_held   <= 1'b0;
                    end
                end
                WR_RESP: begin
                    if (BREADY) begin
                        wr_state <= WR_IDLE;
                        BVALID   <= 1'b0;
                    end
                end
                default: wr_state <= WR_IDLE;
            endcase
        end
    end

    // DMA source control registers and their mirrored mask bits
    generate
        for (genvar n = 0; n < 2; n++) begin : g_dma
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    dma_ctl[n] <= src_ctl_s'(4'(`RST_SRC_CTL));                // [R2] [R4]
                end else if (wr_fire && wr_idx == (n == 0 ? `IDX_DMA0_CTL : `IDX_DMA1_CTL)) begin
                    dma_ctl[n] <= src_ctl_s'(wr_val[3:0]);                     // [R6] [R24]
                end else if (wr_fire && wr_idx == `IDX_SRC_MASK) begin
                    dma_ctl[n].mask <= wr_val[`BIT_DMA_LO + n];                // [R23] [R3]
                end
            end

            // Pin feeds either the interrupt or a DMA request
            assign dma_set[n] = PIN_IS_IRQ[n] ? (pin_sync[n] && !pin_prev[n]) : DMA_DONE[n]; // [R5]
            assign dma_ok[n]  = dma_pend[n] && !dma_ctl[n].mask &&            // [R3]
                                dma_ctl[n].prio <= prio_thresh &&             // [R22]
                                !in_service[`BIT_DMA_LO + n];                 // [R18]
        end
    endgenerate

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            prio_thresh <= `RST_PRIO_THRESH;
        end else if (wr_fire && wr_idx == `IDX_PRIO_THRESH) begin
            prio_thresh <= wr_val[2:0];
        end
    end

    // Halt flag: set wins over clear and over a software write
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            halt <= 1'b0;
        end else if (NMI_EVENT) begin
            halt <= 1'b1;                                                     // [R8]
        end else if (wr_fire && wr_idx == `IDX_STATUS && !SLAVE_MODE) begin
            halt <= wr_val[`BIT_DMA_HALT];                                    // [R9]
        end else if (RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC) begin
            halt <= 1'b0;                                                     // [R8]
        end
    end

    // Timer request bits
    assign tmr_take = TAKE ? {TAKE_TYPE == `TYPE_TIMER2_REQUEST_BIT, TAKE_TYPE == `TYPE_TIMER1_REQUEST_BIT,
                              TAKE_TYPE == `TYPE_TIMER0_REQUEST_BIT} : 3'h0;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            tmr_pend <= 3'h0;
        end else if (wr_fire && wr_idx == `IDX_STATUS && !SLAVE_MODE) begin
            tmr_pend <= wr_val[2:0] | TIMER_REQ;                              // [R9]
        end else begin
            tmr_pend <= (tmr_pend & ~tmr_take) | TIMER_REQ;                   // [R10]
        end
    end

    // DMA pending and slave request latches
    assign take_bit = TAKE ? type_bit(TAKE_TYPE, SLAVE_MODE) : 16'h0000;
    assign eoi_bit  = (wr_fire && wr_idx == `IDX_EOI && !wr_val[`BIT_EOI_NONSPEC]) ?
                      type_bit(wr_val[7:0], SLAVE_MODE) : 16'h0000;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            dma_pend <= 2'h0;
            slv_pend <= `RST_FLAGS;                                           // [R15]
        end else begin
            dma_pend <= (dma_pend & ~take_bit[3:2]) | dma_set;
            slv_pend <= (slv_pend & ~take_bit) |                              // [R15]
                        {10'h000, TIMER_REQ[2], TIMER_REQ[1], dma_set, 1'b0, TIMER_REQ[0]}; // [R16]
        end
    end

    // In-service flags: taking an interrupt wins over its end-of-interrupt
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            in_service <= `RST_FLAGS;                                         // [R20]
        end else begin
            in_service <= (in_service & ~eoi_bit) | take_bit;                // [R17] [R21]
        end
    end

    // Presented request lines in the selected layout
    assign req_master = {5'h00, SERIAL_EN && |SERIAL_SRC,                     // [R14]
                         WDOG_REQ, EXT_REQ, dma_pend, 1'b0, |tmr_pend};       // [R13] [R11]
    assign req_view   = SLAVE_MODE ? slv_pend : req_master;                   // [R25] [R12]
    assign block      = in_service & ~{10'h000, EXT_NESTED & {2{!SLAVE_MODE}}, 4'h0} & // [R19]
                        {5'h00, {11{1'b1}}};

    // Outputs toward DMA and core
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            DMA_HALT      <= 1'b0;
            DMA_PIN_REQ   <= 2'h0;
            DMA_IRQ       <= 1'b0;
            DMA_IRQ_TYPE  <= `TYPE_DMA0;
            REQ_UNBLOCKED <= 16'h0000;
        end else begin
            DMA_HALT      <= halt;                                            // [R7]
            DMA_PIN_REQ   <= pin_sync & ~PIN_IS_IRQ & {2{!halt}};             // [R7] [R5]
            DMA_IRQ       <= |dma_ok;
            DMA_IRQ_TYPE  <= (dma_ok[0] && (!dma_ok[1] || dma_ctl[0].prio <= dma_ctl[1].prio)) ?
                             `TYPE_DMA0 : `TYPE_DMA1;                         // [R1] [R22]
            REQ_UNBLOCKED <= req_view & ~block;                               // [R18]
        end
    end

    // Read channel
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= `RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !ARREADY;
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP  <= `RESP_OKAY;
                case (rd_idx)                                                 // [R24]
                    `IDX_DMA0_CTL:    RDATA <= {28'h000_0000, dma_ctl[0]};
                    `IDX_DMA1_CTL:    RDATA <= {28'h000_0000, dma_ctl[1]};
                    `IDX_STATUS:      RDATA <= {16'h0000, halt, 12'h000, tmr_pend}; // [R10]
                    `IDX_PENDING:     RDATA <= {16'h0000, req_view};          // [R12]
                    `IDX_IN_SERVICE:  RDATA <= {16'h0000, in_service};        // [R21]
                    `IDX_SRC_MASK:    RDATA <= {28'h000_0000, dma_ctl[1].mask,
                                                dma_ctl[0].mask, 2'h0};       // [R3]
                    `IDX_PRIO_THRESH: RDATA <= {29'h0000_0000, prio_thresh};
                    `IDX_EOI:         RDATA <= 32'h0000_0000;
                    default: begin
                        RDATA <= 32'h0000_0000;
                        RRESP <= `RESP_SLVERR;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // Checks
    a_halt_set: assert property (@(posedge CLOCK) disable iff (!NRST)
        NMI_EVENT |=> halt ##1 DMA_HALT) else $error("halt not set by nmi"); // [R8]
    a_halt_clr: assert property (@(posedge CLOCK) disable iff (!NRST)
        RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC && !NMI_EVENT && !wr_fire |=> !halt) else $error("halt not cleared"); // [R8]
    a_halt_stop: assert property (@(posedge CLOCK) disable iff (!NRST)
        DMA_HALT |-> DMA_PIN_REQ == 2'h0) else $error("dma active while halted"); // [R7]
    a_tmr_or: assert property (@(posedge CLOCK) disable iff (!NRST)
        !SLAVE_MODE |-> req_view[0] == |tmr_pend) else $error("timer or wrong"); // [R11]
    a_mask_block: assert property (@(posedge CLOCK) disable iff (!NRST)
        dma_ctl[0].mask && dma_ctl[1].mask |=> !DMA_IRQ) else $error("masked dma irq"); // [R3]
    a_srv_block: assert property (@(posedge CLOCK) disable iff (!NRST)
        in_service[2] && in_service[3] |=> !DMA_IRQ) else $error("in service request"); // [R18]
    a_take_srv: assert property (@(posedge CLOCK) disable iff (!NRST)
        TAKE && TAKE_TYPE == `TYPE_DMA1 |=> in_service[3]) else $error("no in service"); // [R17]
    a_prio_gate: assert property (@(posedge CLOCK) disable iff (!NRST)
        dma_ctl[0].prio > prio_thresh && dma_ctl[1].prio > prio_thresh |=> !DMA_IRQ)
        else $error("priority threshold ignored"); // [R22]
    a_serial_or: assert property (@(posedge CLOCK) disable iff (!NRST)
        !SLAVE_MODE && !SERIAL_EN |-> !req_view[`BIT_SERIAL]) else $error("serial not gated"); // [R14]
    a_slave_rsv: assert property (@(posedge CLOCK) disable iff (!NRST)
        SLAVE_MODE |-> req_view[15:6] == 10'h000 && !req_view[1]) else $error("reserved set"); // [R24]

endmodule

// ==== tb/core_model.sv ====
// Behavioural core that takes the DMA interrupt offered by the block.
// Assumes the block's CLOCK and NRST; ENABLE lets the bench hold off taking.
`timescale 1ns/1ps
module core_model #(
    parameter int DLY = 3
) (
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       NRST,
    // Bench enable and offer from the block
    input  wire logic       ENABLE,
    input  wire logic       DMA_IRQ,
    input  wire logic [7:0] DMA_IRQ_TYPE,
    // Acknowledge to the block
    output logic            TAKE,
    output logic [7:0]      TAKE_TYPE
);
    initial begin
        TAKE = 1'b0;
        TAKE_TYPE = 8'h00;
    end
    // Takes the offered type after DLY cycles, then pauses three cycles before looking again
    always begin
        @(posedge CLOCK);
        if (NRST && ENABLE && DMA_IRQ === 1'b1) begin
            repeat (DLY) @(posedge CLOCK);
            TAKE <= 1'b1;
            TAKE_TYPE <= DMA_IRQ_TYPE;
            @(posedge CLOCK);
            TAKE <= 1'b0;
            TAKE_TYPE <= ~TAKE_TYPE;
            repeat (3) @(posedge CLOCK);
        end
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the interrupt status and DMA source registers.
// Assumes the core model beside it; AXI4-Lite master driven on rising edges.
`timescale 1ns/1ps
`include "irq_status_consts.svh"
module tb;
    import irq_status_pkg::*;
    logic        clock = 1'b0, nrst = 1'b0;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awready, wready, bvalid, arready, rvalid, dma_halt, dma_irq, take;
    logic [1:0]  bresp, rresp, dma_pin_req, dma_done = 2'b00, shared_pin = 2'b00;
    logic [1:0]  pin_is_irq = 2'b11;
    logic [31:0] rdata;
    logic [7:0]  dma_irq_type, take_type;
    logic [15:0] req_unblocked;
    logic        slave_mode = 1'b0, nmi = 1'b0, return_from_interrupt_instruction = 1'b0, core_en = 1'b0, serial_en = 1'b0;
    logic [2:0]  timer_req = 3'b000;
    logic [5:0]  serial_src = 6'b00_0000;
    logic        wdog_req = 1'b0;
    logic [4:0]  ext_req = 5'h00;
    logic [31:0] d;
    logic [1:0]  r;
    int          fails = 0, checks_done = 0;

    always #12.5 clock = ~clock;

    irq_status_regs irq_status_regs_inst (.CLOCK(clock), .NRST(nrst), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .SLAVE_MODE(slave_mode), .NMI_EVENT(nmi), .RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC(return_from_interrupt_instruction),
        .TAKE(take), .TAKE_TYPE(take_type), .TIMER_REQ(timer_req), .DMA_DONE(dma_done),
        .EXT_REQ(ext_req), .EXT_NESTED(2'b00), .WDOG_REQ(wdog_req), .SERIAL_SRC(serial_src),
        .SERIAL_EN(serial_en), .SHARED_PIN(shared_pin), .PIN_IS_IRQ(pin_is_irq),
        .DMA_HALT(dma_halt), .DMA_PIN_REQ(dma_pin_req), .DMA_IRQ(dma_irq),
        .DMA_IRQ_TYPE(dma_irq_type), .REQ_UNBLOCKED(req_unblocked));

    core_model core_model_inst (.CLOCK(clock), .NRST(nrst), .ENABLE(core_en),
        .DMA_IRQ(dma_irq), .DMA_IRQ_TYPE(dma_irq_type), .TAKE(take), .TAKE_TYPE(take_type));

    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Handshakes are judged at the falling edge and acted on at the next rising edge
    task automatic wr(input logic [7:0] idx, input logic [15:0] v);
        logic aw, w, b;
        int   n;
        n = 0;
        b = 1'b0;
        @(posedge clock);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b && n < 50) begin
            @(negedge clock);
            aw = awvalid && awready === 1'b1;
            w = wvalid && wready === 1'b1;
            b = bvalid === 1'b1;
            n++;
            @(posedge clock);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!b) chk(1'b0, 1'b1, "write response");
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        v = 32'hDEAD_BEEF;
        rs = 2'b11;
        @(posedge clock);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(negedge clock);
            n++;
            if (rvalid === 1'b1) begin
                v = rdata;
                rs = rresp;
                n = 99;
            end
            @(posedge clock);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end
        arvalid <= 1'b0;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [15:0] exp, input string what);
        rd(idx, d, r);
        chk({r, d}, {`RESP_OKAY, 16'h0000, exp}, what);
    endtask

    task automatic do_reset(input logic mode);
        @(posedge clock);
        nrst <= 1'b0;
        slave_mode <= mode;
        cyc(12);
        nrst <= 1'b1;
    endtask

    task automatic t_reset_vals();
        rchk(`IDX_DMA0_CTL, `RST_SRC_CTL, "dma0 ctl reset");
        rchk(`IDX_DMA1_CTL, `RST_SRC_CTL, "dma1 ctl reset");
        rchk(`IDX_IN_SERVICE, `RST_FLAGS, "in-service reset");
        rd(8'h3F, d, r);
        chk({r, d}, {`RESP_SLVERR, 32'h0000_0000}, "unmapped read");
        wr(`IDX_DMA0_CTL, 16'hFFF2);
        rchk(`IDX_DMA0_CTL, 16'h0002, "reserved bits");
        wr(`IDX_SRC_MASK, 16'hFFFF);
        rchk(`IDX_DMA0_CTL, 16'h000A, "mask mirror");
        rchk(`IDX_SRC_MASK, 16'h000C, "mask read");
        wr(`IDX_SRC_MASK, 16'h0008);
        rchk(`IDX_DMA0_CTL, 16'h0002, "mask clear");
    endtask

    task automatic t_dma_irq();
        @(posedge clock);
        pin_is_irq <= 2'b10;
        shared_pin <= 2'b10;
        dma_done <= 2'b01;
        @(posedge clock);
        dma_done <= 2'b00;
        cyc(3);
        chk({dma_irq, dma_irq_type}, {1'b1, `TYPE_DMA0}, "dma0 offer");
        rchk(`IDX_PENDING, 16'h000C, "pending dma bits");
        core_en <= 1'b1;
        cyc(10);
        rchk(`IDX_IN_SERVICE, 16'h0004, "dma0 in service");
        dma_done <= 2'b01;
        @(posedge clock);
        dma_done <= 2'b00;
        cyc(3);
        chk({dma_irq, req_unblocked}, {1'b0, 16'h0008}, "blocked in service");
        core_en <= 1'b0;
        wr(`IDX_EOI, 16'h000A);
        rchk(`IDX_IN_SERVICE, 16'h0000, "eoi clears");
        core_en <= 1'b1;
        wr(`IDX_PRIO_THRESH, 16'h0000);
        wr(`IDX_DMA1_CTL, 16'h0001);
        cyc(3);
        chk(dma_irq, 1'b0, "threshold masks");
        rchk(`IDX_PRIO_THRESH, 16'h0000, "threshold read");
        wr(`IDX_PRIO_THRESH, 16'h0001);
        cyc(3);
        chk({dma_irq, dma_irq_type}, {1'b1, `TYPE_DMA1}, "dma1 offer");
        cyc(12);
        rchk(`IDX_IN_SERVICE, 16'h000C, "both in service");
        wr(`IDX_EOI, 16'h000B);
        wr(`IDX_EOI, 16'h000A);
        core_en <= 1'b0;
    endtask

    task automatic t_halt();
        pin_is_irq <= 2'b00;
        shared_pin <= 2'b01;
        cyc(6);
        chk(dma_pin_req, 2'b01, "pin as dma request");
        nmi <= 1'b1;
        @(posedge clock);
        nmi <= 1'b0;
        cyc(3);
        chk({dma_halt, dma_pin_req}, 3'b100, "halt on nmi");
        rchk(`IDX_STATUS, 16'h8000, "halt flag read");
        return_from_interrupt_instruction <= 1'b1;
        @(posedge clock);
        return_from_interrupt_instruction <= 1'b0;
        cyc(3);
        chk({dma_halt, dma_pin_req}, 3'b001, "return_from_interrupt_instruction clears halt");
        wr(`IDX_STATUS, 16'h8000);
        cyc(2);
        chk(dma_halt, 1'b1, "software halt");
        wr(`IDX_STATUS, 16'h0000);
    endtask

    task automatic t_timers();
        serial_en <= 1'b1;
        serial_src <= 6'b00_0100;
        timer_req <= 3'b101;
        wdog_req <= 1'b1;
        ext_req <= 5'h11;
        @(posedge clock);
        timer_req <= 3'b000;
        cyc(3);
        rchk(`IDX_STATUS, 16'h0005, "timer status");
        rchk(`IDX_PENDING, 16'h0711, "timer or and serial");
        chk(req_unblocked, 16'h0711, "unblocked view");
        wdog_req <= 1'b0;
        ext_req <= 5'h00;
        wr(`IDX_STATUS, 16'h0000);
    endtask

    task automatic t_slave();
        do_reset(1'b1);
        rchk(`IDX_DMA1_CTL, `RST_SRC_CTL, "slave ctl reset");
        rchk(`IDX_PENDING, `RST_FLAGS, "slave pending reset");
        timer_req <= 3'b110;
        @(posedge clock);
        timer_req <= 3'b000;
        cyc(3);
        rchk(`IDX_PENDING, 16'h0030, "slave timer layout");
        wr(`IDX_STATUS, 16'h8000);
        rchk(`IDX_STATUS, 16'h0006, "slave status write ignored");
        rchk(`IDX_IN_SERVICE, 16'h0000, "slave in-service");
        wr(`IDX_DMA1_CTL, 16'h0001);
        @(posedge clock);
        dma_done <= 2'b10;
        core_en <= 1'b1;
        @(posedge clock);
        dma_done <= 2'b00;
        cyc(10);
        rchk(`IDX_IN_SERVICE, 16'h0008, "slave dma1 in service");
        rchk(`IDX_PENDING, 16'h0030, "slave ack clears");
        core_en <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        fails++;
        conclude();
    end

    initial begin
        do_reset(1'b0);
        t_reset_vals();
        t_dma_irq();
        t_halt();
        t_timers();
        t_slave();
        conclude();
    end
endmodule
